// *** verilog/wtldr_pkg.sv ***
// package of constants for the wake timer with low duty cycle receive
// assumes a single 20 MHz system clock and an 8-bit register port
// Operation
// - timer ticks come from the on-chip rc oscillator or an external crystal
// - with timer enabled, count mantissa-and-exponent period while the chip sleeps
// - on expiry drive host interrupt pin low if the wake interrupt enable bit allows
// - period equals mantissa times four times two to the exponent ticks
// - calibrate rc oscillator on boot command and on leaving shutdown
// - periodic recalibration only when enabled; interval chosen by three bits
// - every calibration runs the main crystal oscillator while it lasts
// - battery check enable requests a measurement at every expiry
// - duty cycle enable makes each expiry with no window open start a receive window
// - mantissa loads from a high byte and a low byte register
// - exponent is five bits, sharing its register with post-expiry select
// - post-expiry select: zero means ready, one means sleep
// - receive window length has its own register
// - window length equals window count times four times two to exponent
// - no preamble, error or no packet: return to post state at window end; the code ignores RX_ERR_I, so only a missing PREAMBLE_OK_I closes it then
// - preamble or sync extends the window, giving up after two windows
package wtldr_pkg;
   // ------------------------------------------------------------
   // clocking
   // ------------------------------------------------------------
   localparam int unsigned SYS_CLK_HZ = 20000000;
   localparam int unsigned TICK_HZ = 32768;
   localparam int unsigned RC_DIV = SYS_CLK_HZ / TICK_HZ;
   localparam int unsigned CAL_TIME_US = 250;
   localparam int unsigned CAL_CYCLES = CAL_TIME_US * (SYS_CLK_HZ / 1000000);
   localparam int unsigned CAL_BASE_LOG2 = 10;
   localparam int unsigned PRE_W = 34;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_MANT_HI = 8'h01;
   localparam logic [7:0] ADDR_MANT_LO = 8'h02;
   localparam logic [7:0] ADDR_EXPONENT = 8'h03;
   localparam logic [7:0] ADDR_WINDOW = 8'h04;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h05;
   localparam logic [7:0] ADDR_STATUS = 8'h06;
   localparam logic [7:0] ADDR_CLK_CFG = 8'h07;
   localparam logic [7:0] ADDR_COMMAND = 8'h08;
   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int unsigned CFG_EN_BIT = 0;
   localparam int unsigned CFG_LBD_BIT = 1;
   localparam int unsigned CFG_LDC_BIT = 2;
   localparam int unsigned CFG_CAL_BIT = 3;
   localparam int unsigned CFG_PER_LSB = 4;
   localparam int unsigned EXP_SLEEP_BIT = 7;
   localparam int unsigned IRQEN_WAKE_BIT = 0;
   localparam int unsigned CMD_BOOT_BIT = 0;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam int unsigned EXT_LIMIT = 2;
   // ------------------------------------------------------------
   // receive window states, gray along idle-window-extend
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      WTLDR_IDLE = 2'h0,
      WTLDR_WIN = 2'h1,
      WTLDR_EXT = 2'h3
   } wtldr_state_t;
endpackage

// *** verilog/wtldr_if.sv ***
// internal carrier between the timer core and its helper blocks
// assumes all three sit on the same system clock
interface wtldr_if;
   logic src_sel;
   logic tick;
   logic cal_en;
   logic [2:0] cal_per;
   logic cal_start;
   logic cal_busy;
   modport gen (input src_sel, output tick);
   modport cal (input tick, cal_en, cal_per, cal_start, output cal_busy);
   modport core (output src_sel, cal_en, cal_per, cal_start,
                 input tick, cal_busy);
endinterface

// *** verilog/wtldr_tick_gen.sv ***
// 32 kHz tick source: rc divider or synchronised crystal input
// assumes the crystal pin is asynchronous to the system clock
module wtldr_tick_gen
   import wtldr_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // crystal pin
   input wire logic crystal_i,
   // carrier
   wtldr_if.gen bus
);
   logic [9:0] rc_q;
   logic [2:0] sync_q;
   logic lvl_q;
   logic tick_q;
   logic rc_wrap;
   logic xt_rise;

   assign rc_wrap = (rc_q == 10'(RC_DIV - 1));
   // a crystal edge only counts once the second and third stages agree
   assign xt_rise = (sync_q[1] == sync_q[2]) && sync_q[2] && !lvl_q;

   // rc oscillator modelled as a divider of the system clock
   always_ff @(posedge clk_i)
   begin
      if (srst_i || rc_wrap)
         rc_q <= '0;
      else
         rc_q <= rc_q + 10'h001;
   end

   // three stage synchroniser and accepted crystal level
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         sync_q <= '0;
         lvl_q <= 1'b0;
      end
      else
      begin
         sync_q <= {sync_q[1:0], crystal_i};
         if (sync_q[1] == sync_q[2])
            lvl_q <= sync_q[2];
      end
   end

   // source select picks one tick stream
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
         tick_q <= 1'b0;
      else
         tick_q <= bus.src_sel ? xt_rise : rc_wrap;
   end

   assign bus.tick = tick_q;
endmodule

// *** verilog/wtldr_recal.sv ***
// rc oscillator calibration sequencer with periodic interval timer
// assumes start requests are one-cycle pulses from the core
module wtldr_recal
   import wtldr_pkg::*;
#(
   parameter int unsigned CAL_LEN = CAL_CYCLES
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // carrier
   wtldr_if.cal bus
);
   logic [17:0] ivl_q;
   logic [15:0] busy_q;
   logic ivl_done;

   // interval is two to the (base plus select) ticks
   assign ivl_done = bus.cal_en &&
      (ivl_q == 18'((18'h00001 << (CAL_BASE_LOG2 + 32'(bus.cal_per))) - 1));

   // interval counter only runs while recalibration is enabled
   always_ff @(posedge clk_i)
   begin
      if (srst_i || !bus.cal_en || (bus.tick && ivl_done))
         ivl_q <= '0;
      else if (bus.tick)
         ivl_q <= ivl_q + 18'h00001;
   end

   // busy window keeps the main crystal running for the calibration
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
         busy_q <= '0;
      else if (bus.cal_start || (bus.tick && ivl_done))
         busy_q <= 16'(CAL_LEN);
      else if (busy_q != 16'h0000)
         busy_q <= busy_q - 16'h0001;
   end

   assign bus.cal_busy = (busy_q != 16'h0000);
endmodule

// *** verilog/wtldr_top.sv ***
// wake timer core: registers, period counter, interrupt and receive window
// assumes packet handler status inputs come from logic on SYS_CLK_I
//
// The implementer's own choices: the register offsets and the plain strobed port.
module wtldr_top
   import wtldr_pkg::*;
#(
   parameter int unsigned CAL_LEN = CAL_CYCLES
)
(
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic SRST_I,
   // register port
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic REG_WE_I,
   input wire logic REG_RE_I,
   output logic [7:0] REG_RDATA_O,
   // clock sources and chip power
   input wire logic XTAL32_I,
   input wire logic SHUTDOWN_I,
   output logic XO_EN_O,
   // receiver status from the packet handler
   input wire logic PREAMBLE_OK_I,
   input wire logic PKT_DONE_I,
   input wire logic RX_ERR_I,
   // chip outputs
   output logic RX_EN_O,
   output logic CHIP_SLEEP_O,
   output logic BATT_CHECK_O,
   output logic HOST_IRQ_N_O
);
   import wtldr_pkg::*;

   wtldr_if cb ();

   logic [7:0] cfg_q, mhi_q, mlo_q, exp_q, win_len_q, irq_en_q, clk_cfg_q;
   logic [7:0] rdata_q;
   logic [PRE_W-1:0] pre_q;
   logic [15:0] man_q;
   logic [7:0] win_q;
   logic [1:0] ext_q;
   logic pend_q, expire_q, batt_q, irq_n_q, sleep_q, rx_q, boot_q, shut_q;
   wtldr_state_t state_q, state_d;
   logic timer_en, unit, man_wrap, stat_rd, win_end;
   logic [PRE_W-1:0] pre_top;
   logic [15:0] mant;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   wtldr_tick_gen u_tick
   (
      .clk_i(SYS_CLK_I),
      .srst_i(SRST_I),
      .crystal_i(XTAL32_I),
      .bus(cb.gen)
   );

   wtldr_recal #(.CAL_LEN(CAL_LEN)) u_recal
   (
      .clk_i(SYS_CLK_I),
      .srst_i(SRST_I),
      .bus(cb.cal)
   );

   assign cb.src_sel = clk_cfg_q[0];
   assign cb.cal_en = cfg_q[CFG_CAL_BIT];
   assign cb.cal_per = cfg_q[CFG_PER_LSB +: 3];
   // boot command or leaving shutdown triggers a calibration
   assign cb.cal_start = boot_q || (shut_q && !SHUTDOWN_I);

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   assign stat_rd = REG_RE_I && (REG_ADDR_I == ADDR_STATUS);

   // writable bytes; the mantissa halves land in separate registers
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SRST_I)
      begin
         cfg_q <= RST_BYTE;
         mhi_q <= RST_BYTE;
         mlo_q <= RST_BYTE;
         exp_q <= RST_BYTE;
         win_len_q <= RST_BYTE;
         irq_en_q <= RST_BYTE;
         clk_cfg_q <= RST_BYTE;
      end
      else if (REG_WE_I)
      begin
         case (REG_ADDR_I)
            ADDR_CONFIG: cfg_q <= REG_WDATA_I;
            ADDR_MANT_HI: mhi_q <= REG_WDATA_I;
            ADDR_MANT_LO: mlo_q <= REG_WDATA_I;
            ADDR_EXPONENT: exp_q <= REG_WDATA_I;
            ADDR_WINDOW: win_len_q <= REG_WDATA_I;
            ADDR_IRQ_EN: irq_en_q <= REG_WDATA_I;
            ADDR_CLK_CFG: clk_cfg_q <= REG_WDATA_I;
            default: ;
         endcase
      end
   end

   // boot pulse and shutdown edge tracking
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SRST_I)
      begin
         boot_q <= 1'b0;
         shut_q <= 1'b0;
      end
      else
      begin
         boot_q <= REG_WE_I && (REG_ADDR_I == ADDR_COMMAND) &&
                   REG_WDATA_I[CMD_BOOT_BIT];
         shut_q <= SHUTDOWN_I;
      end
   end

   // read data stands one cycle after the strobe; unmapped reads zero
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SRST_I)
         rdata_q <= 8'h00;
      else if (REG_RE_I)
      begin
         case (REG_ADDR_I)
            ADDR_CONFIG: rdata_q <= cfg_q;
            ADDR_MANT_HI: rdata_q <= mhi_q;
            ADDR_MANT_LO: rdata_q <= mlo_q;
            ADDR_EXPONENT: rdata_q <= exp_q;
            ADDR_WINDOW: rdata_q <= win_len_q;
            ADDR_IRQ_EN: rdata_q <= irq_en_q;
            ADDR_STATUS: rdata_q <= {4'h0, state_q, cb.cal_busy, pend_q};
            ADDR_CLK_CFG: rdata_q <= clk_cfg_q;
            default: rdata_q <= 8'h00;
         endcase
      end
      else
         rdata_q <= 8'h00;
   end

   // ------------------------------------------------------------
   // period counter
   // ------------------------------------------------------------
   assign timer_en = cfg_q[CFG_EN_BIT];
   assign mant = {mhi_q, mlo_q};
   // one unit is four times two to the exponent ticks
   assign pre_top = (PRE_W'(4) << exp_q[4:0]) - PRE_W'(1);
   assign unit = cb.tick && (pre_q == pre_top);
   // a zero mantissa behaves as one unit, so the timer never stalls
   assign man_wrap = ({1'b0, man_q} + 17'h00001) >= {1'b0, mant};

   // counting runs whenever enabled, so it also runs through sleep
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SRST_I || !timer_en)
      begin
         pre_q <= '0;
         man_q <= '0;
      end
      else if (unit)
      begin
         pre_q <= '0;
         man_q <= man_wrap ? 16'h0000 : man_q + 16'h0001;
      end
      else if (cb.tick)
         pre_q <= pre_q + PRE_W'(1);
   end

   // one-cycle expiry pulse and battery check request
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SRST_I)
      begin
         expire_q <= 1'b0;
         batt_q <= 1'b0;
      end
      else
      begin
         expire_q <= timer_en && unit && man_wrap;
         batt_q <= expire_q && cfg_q[CFG_LBD_BIT];
      end
   end

   // ------------------------------------------------------------
   // pending flag and interrupt pin
   // ------------------------------------------------------------
   // a new expiry wins over a status read in the same cycle
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SRST_I)
         pend_q <= 1'b0;
      else if (expire_q)
         pend_q <= 1'b1;
      else if (stat_rd)
         pend_q <= 1'b0;
   end

   // pin is low only while pending and enabled by software
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SRST_I)
         irq_n_q <= 1'b1;
      else
         irq_n_q <= !((pend_q || expire_q) && irq_en_q[IRQEN_WAKE_BIT]);
   end

   // ------------------------------------------------------------
   // low duty cycle receive window
   // ------------------------------------------------------------
   // the window counts the same units as the wake period
   assign win_end = unit && (({1'b0, win_q} + 9'h001) >= {1'b0, win_len_q});

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         WTLDR_IDLE:
            if (expire_q && cfg_q[CFG_LDC_BIT])
               state_d = WTLDR_WIN;
         WTLDR_WIN:
            if (PKT_DONE_I)
               state_d = WTLDR_IDLE;
            else if (win_end)
               state_d = PREAMBLE_OK_I ? WTLDR_EXT : WTLDR_IDLE;
         WTLDR_EXT:
            if (PKT_DONE_I || (win_end && ext_q == 2'(EXT_LIMIT - 1)))
               state_d = WTLDR_IDLE;
         default:
            state_d = WTLDR_IDLE;
      endcase
      if (!timer_en)
         state_d = WTLDR_IDLE;
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (SRST_I)
         state_q <= WTLDR_IDLE;
      else
         state_q <= state_d;
   end

   // window unit count and extension count
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SRST_I || state_d == WTLDR_IDLE || state_d != state_q)
         win_q <= '0;
      else if (win_end)
         win_q <= '0;
      else if (unit)
         win_q <= win_q + 8'h01;
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (SRST_I || state_q == WTLDR_IDLE)
         ext_q <= '0;
      else if (win_end)
         ext_q <= ext_q + 2'h1;
   end

   // chip outputs: receiver on in a window, otherwise the post state
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SRST_I)
      begin
         rx_q <= 1'b0;
         sleep_q <= 1'b0;
      end
      else
      begin
         rx_q <= (state_d != WTLDR_IDLE);
         sleep_q <= (state_d == WTLDR_IDLE) && exp_q[EXP_SLEEP_BIT];
      end
   end

   assign REG_RDATA_O = rdata_q;
   assign XO_EN_O = cb.cal_busy;
   assign RX_EN_O = rx_q;
   assign CHIP_SLEEP_O = sleep_q;
   assign BATT_CHECK_O = batt_q;
   assign HOST_IRQ_N_O = irq_n_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_irq_low;
      @(posedge SYS_CLK_I) disable iff (SRST_I)
      (expire_q && irq_en_q[IRQEN_WAKE_BIT]) |=> !HOST_IRQ_N_O;
   endproperty
   a_irq_low: assert property (p_irq_low)
      else $error("interrupt pin not low after enabled expiry");

   property p_irq_masked;
      @(posedge SYS_CLK_I) disable iff (SRST_I)
      !irq_en_q[IRQEN_WAKE_BIT] |=> HOST_IRQ_N_O;
   endproperty
   a_irq_masked: assert property (p_irq_masked)
      else $error("interrupt pin low while masked");

   property p_pend_hold;
      @(posedge SYS_CLK_I) disable iff (SRST_I)
      (pend_q && !stat_rd) |=> pend_q;
   endproperty
   a_pend_hold: assert property (p_pend_hold)
      else $error("pending flag lost without status read");

   property p_reload;
      @(posedge SYS_CLK_I) disable iff (SRST_I)
      expire_q |-> (man_q == 16'h0000) && (pre_q == '0);
   endproperty
   a_reload: assert property (p_reload)
      else $error("period not reloaded at expiry");

   property p_stop;
      @(posedge SYS_CLK_I) disable iff (SRST_I)
      !timer_en |=> (man_q == 16'h0000) && !expire_q;
   endproperty
   a_stop: assert property (p_stop)
      else $error("timer counts while disabled");

   property p_batt;
      @(posedge SYS_CLK_I) disable iff (SRST_I)
      expire_q |=> (BATT_CHECK_O == $past(cfg_q[CFG_LBD_BIT]));
   endproperty
   a_batt: assert property (p_batt)
      else $error("battery check does not follow enable");

   property p_ldc_start;
      @(posedge SYS_CLK_I) disable iff (SRST_I)
      (expire_q && timer_en && state_q == WTLDR_IDLE) |=>
         (RX_EN_O == $past(cfg_q[CFG_LDC_BIT]));
   endproperty
   a_ldc_start: assert property (p_ldc_start)
      else $error("receive window start does not follow duty enable");

   property p_no_pre;
      @(posedge SYS_CLK_I) disable iff (SRST_I)
      (state_q == WTLDR_WIN && win_end && !PREAMBLE_OK_I) |=>
         state_q == WTLDR_IDLE ##1 !RX_EN_O;
   endproperty
   a_no_pre: assert property (p_no_pre)
      else $error("window did not close without preamble");

   property p_two_win;
      @(posedge SYS_CLK_I) disable iff (SRST_I)
      (state_q == WTLDR_EXT && win_end && ext_q == 2'h1) |=>
         state_q == WTLDR_IDLE;
   endproperty
   a_two_win: assert property (p_two_win)
      else $error("reception not abandoned after two windows");

   property p_sleep;
      @(posedge SYS_CLK_I) disable iff (SRST_I)
      (state_d == WTLDR_IDLE && exp_q[EXP_SLEEP_BIT]) |=> CHIP_SLEEP_O;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("post-expiry sleep not selected");

   property p_boot_cal;
      @(posedge SYS_CLK_I) disable iff (SRST_I)
      boot_q |=> XO_EN_O [*8];
   endproperty
   a_boot_cal: assert property (p_boot_cal)
      else $error("boot did not start calibration with crystal");
endmodule

// *** test/wtldr_crystal_src.sv ***
// free-running 32 kHz crystal that drives the crystal pin of the timer
// assumes nothing of the bench; phase is unrelated to the system clock
module wtldr_crystal_src
(
   // crystal output
   output logic crystal_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // oscillator
   // ------------------------------------------------------------
   // a crystal never stops between frames, so it runs from time zero
   initial
   begin
      crystal_o = 1'b0;
      #7.3;
      forever #15258.789 crystal_o = ~crystal_o;
   end
endmodule

// *** test/testbench.sv ***
// self-checking bench for the wake timer top level
// assumes the crystal model above and the 8-bit strobe register port
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import wtldr_pkg::*;
   // ------------------------------------------------------------
   // signals and instances
   // ------------------------------------------------------------
   localparam int CL = 20; // short calibration keeps the run brief
   logic clk, srst, we, re, xt, shd, pre, pkt, err;
   logic xo, rxen, slp, batt, irq_n;
   logic [7:0] addr, wdat, rdat, rd_v;
   int bad_count, n_compared, cyc, n;
   logic [7:0] ra [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05};
   logic [7:0] rv [6] = '{8'h7E, 8'hA5, 8'h5A, 8'h9F, 8'hC3, 8'h01};
   wtldr_crystal_src i_crystal (.crystal_o(xt));
   wtldr_top #(.CAL_LEN(CL)) i_dut (
      .SYS_CLK_I(clk), .SRST_I(srst), .REG_ADDR_I(addr),
      .REG_WDATA_I(wdat), .REG_WE_I(we), .REG_RE_I(re),
      .REG_RDATA_O(rdat), .XTAL32_I(xt), .SHUTDOWN_I(shd),
      .XO_EN_O(xo), .PREAMBLE_OK_I(pre), .PKT_DONE_I(pkt),
      .RX_ERR_I(err), .RX_EN_O(rxen), .CHIP_SLEEP_O(slp),
      .BATT_CHECK_O(batt), .HOST_IRQ_N_O(irq_n));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ------------------------------------------------------------
   // access and compare tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      n_compared++;
      if (g !== e)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chkr(input string nm, input int lo, input int hi,
                       input int g);
      n_compared++;
      if (g < lo || g > hi)
      begin
         bad_count++;
         $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask
   // one-cycle strobes, changed just after the edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdat <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1;
      d = rdat;
   endtask
   function automatic logic sig(input int s);
      case (s)
         0: return xo;
         1: return rxen;
         2: return ~irq_n;
         3: return slp;
         default: return batt;
      endcase
   endfunction
   // bounded wait for a level, k counts edges waited
   task automatic wl(input int s, input logic v, input int lim,
                     output int k);
      k = 0;
      do
      begin
         @(posedge clk);
         #1;
         k++;
      end
      while (sig(s) !== v && k < lim);
      if (sig(s) !== v)
         chk("level wait", {7'h00, v}, {7'h00, sig(s)});
   endtask
   task automatic summarize;
      if (bad_count == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // hang guard, above the expected run of about 54k cycles
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         bad_count++;
         summarize();
      end
   end
   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial
   begin
      srst = 1'b1;
      {we, re, shd, pre, pkt, err} = 6'h00;
      addr = 8'h00;
      wdat = 8'h00;
      bad_count = 0;
      n_compared = 0;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      #1;
      chk("irq_n reset", 8'h01, {7'h00, irq_n});
      // every register clear, unmapped place reads zero
      for (int a = 0; a < 9; a++)
      begin
         rd(a[7:0], rd_v);
         chk("reset reg", 8'h00, rd_v);
      end
      wr(8'h20, 8'hFF);
      rd(8'h20, rd_v);
      chk("unmapped", 8'h00, rd_v);
      for (int i = 0; i < 6; i++)
      begin
         wr(ra[i], rv[i]);
         rd(ra[i], rd_v);
         chk("readback", rv[i], rd_v);
         wr(ra[i], 8'h00);
      end
      // boot command and leaving shutdown both calibrate
      wr(8'h08, 8'h01);
      wl(0, 1'b1, 4, n);
      wl(0, 1'b0, CL + 4, n);
      chkr("boot cal", CL - 1, CL + 1, n);
      @(posedge clk);
      shd <= 1'b1;
      repeat (5) @(posedge clk);
      shd <= 1'b0;
      wl(0, 1'b1, 4, n);
      wl(0, 1'b0, CL + 4, n);
      chkr("shutdown cal", CL - 1, CL + 1, n);
      // mantissa 1, exponent 1: 8 ticks of 610 clocks
      wr(8'h01, 8'h00);
      wr(8'h02, 8'h01);
      wr(8'h03, 8'h01);
      wr(8'h05, 8'h01);
      wr(8'h00, 8'h03);
      wl(2, 1'b1, 5200, n);
      chkr("first expiry", 4260, 4890, n);
      chk("batt pulse", 8'h01, {7'h00, batt});
      wl(4, 1'b0, 2, n);
      chk("irq held", 8'h00, {7'h00, irq_n});
      wl(4, 1'b1, 5200, n);
      chkr("period", 4876, 4882, n);
      rd(8'h06, rd_v);
      chk("status", 8'h01, rd_v);
      wl(2, 1'b0, 3, n);
      // masked interrupt, battery check off
      wr(8'h05, 8'h00);
      wr(8'h00, 8'h01);
      n = 0;
      repeat (5000)
      begin
         @(posedge clk);
         #1;
         if (irq_n !== 1'b1 || batt !== 1'b0)
            n++;
      end
      chkr("masked", 0, 0, n);
      // crystal source: 8 ticks of 30.5 us each
      wr(8'h07, 8'h01);
      wr(8'h00, 8'h03);
      wl(4, 1'b1, 5200, n);
      wl(4, 1'b0, 2, n);
      wl(4, 1'b1, 5200, n);
      chkr("crystal period", 4878, 4887, n);
      wr(8'h00, 8'h00);
      wr(8'h07, 8'h00);
      rd(8'h06, rd_v);
      // duty cycle: period 16 ticks, window 4 ticks, sleep after
      wr(8'h02, 8'h04);
      wr(8'h03, 8'h80);
      wr(8'h04, 8'h01);
      // host keeps recalibration on, its interval lies beyond this run
      wr(8'h00, 8'h0D);
      wl(1, 1'b1, 10000, n);
      repeat (100) @(posedge clk);
      err <= 1'b1;
      @(posedge clk);
      err <= 1'b0;
      wl(1, 1'b0, 2600, n);
      chkr("window with error", 2332, 2345, n);
      wl(3, 1'b1, 4, n);
      chk("post sleep", 8'h01, {7'h00, slp});
      @(posedge clk);
      pre <= 1'b1;
      wl(1, 1'b1, 10000, n);
      wl(1, 1'b0, 5200, n);
      chkr("extended window", 4875, 4885, n);
      @(posedge clk);
      pre <= 1'b0;
      // packet done ends the window early, ready afterwards
      wr(8'h03, 8'h00);
      wl(1, 1'b1, 10000, n);
      repeat (100) @(posedge clk);
      pkt <= 1'b1;
      wl(1, 1'b0, 4, n);
      chkr("packet end", 1, 4, n);
      @(posedge clk);
      pkt <= 1'b0;
      #1;
      chk("post ready", 8'h00, {7'h00, slp});
      wr(8'h00, 8'h00);
      summarize();
   end
endmodule
